// ===== period_match_timer.sv
// 8-bit period match timer with prescaler, postscaler and AXI4-Lite slave
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps

module period_match_timer
	import period_timer_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	input wire logic [AXI_DATA_W-1:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	output logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_i,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic [AXI_DATA_W-1:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic match_pulse_o,
	output logic irq_o
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic aw_rdy;
		logic w_rdy;
		logic aw_got;
		logic w_got;
		logic [7:0] waddr;
		logic [7:0] wdata;
		logic wstrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
		logic [6:0] control;
		logic [7:0] count;
		logic [7:0] period;
		logic match_flag;
		logic match_irq_enable;
		logic [3:0] post_count;
		logic match_pulse;
		logic irq;
	} timer_state_t;

	localparam timer_state_t RESET_ST = '{
		aw_rdy: 1'b1,
		w_rdy: 1'b1,
		ar_rdy: 1'b1,
		control: CONTROL_RESET,
		count: COUNT_RESET,
		period: PERIOD_RESET,
		post_count: POST_RESET,
		default: '0
	};

	timer_state_t st;
	timer_state_t next_st;

	reg_sel_t wr_sel;
	reg_sel_t rd_sel;
	logic commit;
	logic wr_en;
	logic ctrl_wr;
	logic cnt_wr;
	logic flags_wr;
	logic scaler_clear;
	logic pre_tick;
	logic wrap;
	logic flag_set;
	logic timer_run_bit;
	logic [1:0] clock_prescale_select;
	logic [3:0] output_postscale_select;

	// ------------------------------------------------------------
	// Read multiplexer
	// ------------------------------------------------------------
	function automatic logic [7:0] read_value(input reg_sel_t sel,
		input timer_state_t s);
		logic [7:0] v;
		v = 8'h00;
		case (sel)
			SEL_CONTROL: v[CTRL_IMPL_W-1:0] = s.control;
			SEL_COUNT: v = s.count;
			SEL_PERIOD: v = s.period;
			SEL_FLAGS: v[FLAG_MATCH_BIT] = s.match_flag;
			SEL_ENABLES: v[ENABLE_MATCH_BIT] = s.match_irq_enable;
			default: v = 8'h00;
		endcase
		return v;
	endfunction : read_value

	// ------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------
	assign timer_run_bit = st.control[CTRL_RUN_BIT];
	assign clock_prescale_select = st.control[CTRL_PRE_LSB +: 2];
	assign output_postscale_select = st.control[CTRL_POST_LSB +: 4];

	// ------------------------------------------------------------
	// Write decode and match detect
	// ------------------------------------------------------------
	// Outside the next-state process, so no loop via the prescaler
	assign wr_sel = decode_addr(st.waddr);
	assign rd_sel = decode_addr(s_axi_araddr_i);
	assign commit = st.aw_got && st.w_got && !st.bvalid;
	assign wr_en = commit && st.wstrb0 && (wr_sel != SEL_NONE);
	assign ctrl_wr = wr_en && (wr_sel == SEL_CONTROL);
	assign cnt_wr = wr_en && (wr_sel == SEL_COUNT);
	assign flags_wr = wr_en && (wr_sel == SEL_FLAGS);
	// scalers clear on count or control write
	assign scaler_clear = ctrl_wr || cnt_wr;
	assign wrap = pre_tick && !cnt_wr && (st.count == st.period);
	// ratio is field value plus one
	assign flag_set = wrap && (st.post_count == output_postscale_select);

	// ------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------
	prescale_divider u_prescale (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.clear_i(scaler_clear),
		.run_i(timer_run_bit),
		.select_i(clock_prescale_select),
		.tick_o(pre_tick)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_st = st;

		// Write address and data, taken in either order
		if (st.aw_rdy && s_axi_awvalid_i)
		begin
			next_st.aw_rdy = 1'b0;
			next_st.aw_got = 1'b1;
			next_st.waddr = s_axi_awaddr_i;
		end
		if (st.w_rdy && s_axi_wvalid_i)
		begin
			next_st.w_rdy = 1'b0;
			next_st.w_got = 1'b1;
			next_st.wdata = s_axi_wdata_i[7:0];
			next_st.wstrb0 = s_axi_wstrb_i[0];
		end
		if (commit)
		begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end
		else if (st.bvalid && s_axi_bready_i)
		begin
			next_st.bvalid = 1'b0;
			next_st.aw_rdy = 1'b1;
			next_st.w_rdy = 1'b1;
		end

		// Read channel, one outstanding
		if (st.ar_rdy && s_axi_arvalid_i)
		begin
			next_st.ar_rdy = 1'b0;
			next_st.rvalid = 1'b1;
			next_st.rdata = read_value(rd_sel, st);
			next_st.rresp = (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end
		else if (st.rvalid && s_axi_rready_i)
		begin
			next_st.rvalid = 1'b0;
			next_st.ar_rdy = 1'b1;
		end

		// Plain register writes
		if (ctrl_wr)
			next_st.control = st.wdata[CTRL_IMPL_W-1:0];
		if (wr_en && (wr_sel == SEL_PERIOD))
			next_st.period = st.wdata;
		if (wr_en && (wr_sel == SEL_ENABLES))
			next_st.match_irq_enable = st.wdata[ENABLE_MATCH_BIT];

		if (cnt_wr)
			next_st.count = st.wdata;
		else if (wrap)
			next_st.count = COUNT_RESET;
		else if (pre_tick)
			next_st.count = st.count + 8'h01;

		next_st.match_pulse = wrap;

		if (scaler_clear)
			next_st.post_count = POST_RESET;
		else if (flag_set)
			next_st.post_count = POST_RESET;
		else if (wrap)
			next_st.post_count = st.post_count + 4'h1;

		if (flag_set)
			next_st.match_flag = 1'b1;
		else if (flags_wr)
			next_st.match_flag = st.wdata[FLAG_MATCH_BIT];

		next_st.irq = st.match_flag && st.match_irq_enable;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			st <= RESET_ST;
		else
			st <= next_st;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign s_axi_awready_o = st.aw_rdy;
	assign s_axi_wready_o = st.w_rdy;
	assign s_axi_bvalid_o = st.bvalid;
	assign s_axi_bresp_o = st.bresp;
	assign s_axi_arready_o = st.ar_rdy;
	assign s_axi_rvalid_o = st.rvalid;
	assign s_axi_rdata_o = {24'h000000, st.rdata};
	assign s_axi_rresp_o = st.rresp;
	assign match_pulse_o = st.match_pulse;
	assign irq_o = st.irq;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence wrap_s;
		pre_tick && !cnt_wr && (st.count == st.period);
	endsequence

	sequence cleared_s;
		(st.count == COUNT_RESET) && match_pulse_o;
	endsequence

	property wrap_p;
		wrap_s |=> cleared_s;
	endproperty

	chk_match_reload: assert property (wrap_p)
		else $error("match did not reload count");

	chk_count_step: assert property (
		(pre_tick && !cnt_wr && st.count != st.period)
		|=> (st.count == $past(st.count) + 8'h01) && !match_pulse_o)
		else $error("count did not step by one");

	chk_stop_holds: assert property (
		(!timer_run_bit && !cnt_wr) |=> $stable(st.count))
		else $error("stopped timer changed count");

	chk_ctrl_keeps: assert property (
		ctrl_wr |=> $stable(st.count) && (st.post_count == POST_RESET))
		else $error("control write disturbed count");

	chk_ctrl_bit7: assert property (
		(s_axi_arvalid_i && s_axi_arready_o
		&& decode_addr(s_axi_araddr_i) == SEL_CONTROL)
		|=> s_axi_rvalid_o && (s_axi_rdata_o[31:7] == 25'h0000000))
		else $error("control bit 7 read nonzero");

	chk_post_ratio: assert property (
		(wrap && st.post_count == output_postscale_select)
		|=> st.match_flag && (st.post_count == POST_RESET))
		else $error("postscaler missed the flag");

	chk_post_early: assert property (
		(wrap && st.post_count != output_postscale_select && !flags_wr
		&& !st.match_flag) |=> !st.match_flag)
		else $error("flag set before ratio reached");

	chk_irq_gate: assert property (
		(st.match_flag && st.match_irq_enable) ##1
		(st.match_flag && st.match_irq_enable) |-> irq_o)
		else $error("enabled flag gave no request");

	chk_irq_masked: assert property (
		!st.match_irq_enable |=> !irq_o)
		else $error("request while disabled");

	chk_reset_state: assert property (
		disable iff (1'b0)
		!reset_n_i |=> (st.count == COUNT_RESET)
		&& (st.period == PERIOD_RESET) && (st.control == CONTROL_RESET))
		else $error("wrong values after reset");

	chk_count_write: assert property (
		cnt_wr |=> (st.post_count == POST_RESET)
		&& (st.count == $past(st.wdata)))
		else $error("count write did not load and clear");

	chk_flag_sticky: assert property (
		(st.match_flag && !flags_wr) |=> st.match_flag)
		else $error("match flag dropped without a clear");

endmodule : period_match_timer

// ===== period_timer_pkg.sv
// Shared constants, types and decode helpers for the period match timer
package period_timer_pkg;

	// ------------------------------------------------------------
	// Bus geometry and responses
	// ------------------------------------------------------------
	localparam int unsigned AXI_ADDR_W = 8;
	localparam int unsigned AXI_DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_COUNT = 8'h04;
	localparam logic [7:0] OFS_PERIOD = 8'h08;
	localparam logic [7:0] OFS_FLAGS = 8'h0C;
	localparam logic [7:0] OFS_ENABLES = 8'h10;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned CTRL_PRE_LSB = 0;
	localparam int unsigned CTRL_RUN_BIT = 2;
	localparam int unsigned CTRL_POST_LSB = 3;
	localparam int unsigned CTRL_IMPL_W = 7;
	localparam int unsigned FLAG_MATCH_BIT = 1;
	localparam int unsigned ENABLE_MATCH_BIT = 1;

	// ------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] PERIOD_RESET = 8'hFF;
	localparam logic [6:0] CONTROL_RESET = 7'h00;
	localparam logic [3:0] POST_RESET = 4'h0;
	localparam logic [3:0] PRE_RESET = 4'h0;

	// ------------------------------------------------------------
	// Prescale codes and last phase of each ratio
	// ------------------------------------------------------------
	localparam logic [1:0] PRE_DIV1 = 2'h0;
	localparam logic [1:0] PRE_DIV4 = 2'h1;
	localparam logic [3:0] PRE_LAST_1 = 4'h0;
	localparam logic [3:0] PRE_LAST_4 = 4'h3;
	localparam logic [3:0] PRE_LAST_16 = 4'hF;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_CONTROL,
		SEL_COUNT,
		SEL_PERIOD,
		SEL_FLAGS,
		SEL_ENABLES
	} reg_sel_t;

	function automatic logic [3:0] prescale_last(input logic [1:0] sel);
		case (sel)
			PRE_DIV1: prescale_last = PRE_LAST_1;
			PRE_DIV4: prescale_last = PRE_LAST_4;
			default: prescale_last = PRE_LAST_16;
		endcase
	endfunction : prescale_last

	function automatic reg_sel_t decode_addr(input logic [7:0] addr);
		case (addr)
			OFS_CONTROL: decode_addr = SEL_CONTROL;
			OFS_COUNT: decode_addr = SEL_COUNT;
			OFS_PERIOD: decode_addr = SEL_PERIOD;
			OFS_FLAGS: decode_addr = SEL_FLAGS;
			OFS_ENABLES: decode_addr = SEL_ENABLES;
			default: decode_addr = SEL_NONE;
		endcase
	endfunction : decode_addr

endpackage : period_timer_pkg

// ===== prescale_divider.sv
// Input clock prescaler producing one tick per selected ratio
`timescale 1ns/100ps
module prescale_divider
	import period_timer_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic clear_i,
	input wire logic run_i,
	input wire logic [1:0] select_i,
	output logic tick_o
);

	typedef struct packed {
		logic [3:0] phase;
	} div_state_t;

	div_state_t st;
	div_state_t next_st;
	logic at_last;

	// ------------------------------------------------------------
	// Phase counter
	// ------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		at_last = (st.phase >= prescale_last(select_i));
		tick_o = run_i && !clear_i && at_last;
		if (clear_i || tick_o)
			next_st.phase = PRE_RESET;
		else if (run_i)
			next_st.phase = st.phase + 4'h1;
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			st <= '{phase: PRE_RESET};
		else
			st <= next_st;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	chk_div4_spacing: assert property (
		(tick_o && select_i == PRE_DIV4)
		|=> (!tick_o || select_i != PRE_DIV4) [*3])
		else $error("divide-by-4 ticked too early");

	chk_clear_phase: assert property (
		clear_i |=> (st.phase == PRE_RESET))
		else $error("prescaler not cleared");

endmodule : prescale_divider

// ===== period_match_timer_tb.sv
// Self-checking testbench for the period match timer
`timescale 1ns/100ps
module period_match_timer_tb
	import period_timer_pkg::*;
;
	// ----------------------------------------
	// Signals and instance
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] q;
		logic [1:0] r;
	} row_t;
	logic clk_i = 1'b0, reset_n_i = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, match_pulse, irq;
	logic [1:0] bresp, rresp, r;
	int err_total = 0, samples_checked = 0, c, k, i, n;
	int divs [4] = '{1, 4, 16, 16};
	int posts [3] = '{0, 3, 15};
	row_t rows [5] = '{
		'{OFS_PERIOD, 32'h5A, 32'h5A, RESP_OKAY},
		'{OFS_COUNT, 32'hFFFFFF33, 32'h33, RESP_OKAY},
		'{OFS_CONTROL, 32'hFB, 32'h7B, RESP_OKAY},
		'{8'h14, 32'h1, 32'h0, RESP_SLVERR},
		'{OFS_ENABLES, 32'h2, 32'h2, RESP_OKAY}};

	always #25 clk_i = ~clk_i;

	period_match_timer u_period_match_timer (
		.clk_i(clk_i), .reset_n_i(reset_n_i),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
		.s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .match_pulse_o(match_pulse), .irq_o(irq));

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			$display("BAD %0t: saw %h, want %h", $time, got, exp);
			err_total++;
		end
	endtask : chk

	task automatic guard(input int m);
		if (m >= 400)
		begin
			$display("BAD %0t: wait ran out", $time);
			err_total++;
			summarize();
		end
	endtask : guard

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int m;
		bit ta = 0, tw = 0, tb = 0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (m = 0; m < 400 && !tb; m++)
		begin
			@(posedge clk_i);
			if (ta && tw && bvalid === 1'b1)
			begin
				tb = 1;
				r = bresp;
				bready <= 1'b0;
			end
			if (!ta && awready === 1'b1)
			begin
				ta = 1;
				awvalid <= 1'b0;
			end
			if (!tw && wready === 1'b1)
			begin
				tw = 1;
				wvalid <= 1'b0;
			end
		end
		guard(m);
		@(posedge clk_i);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int m;
		bit ta = 0, tb = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (m = 0; m < 400 && !tb; m++)
		begin
			@(posedge clk_i);
			if (ta && rvalid === 1'b1)
			begin
				tb = 1;
				d = rdata;
				r = rresp;
				rready <= 1'b0;
			end
			if (!ta && arready === 1'b1)
			begin
				ta = 1;
				arvalid <= 1'b0;
			end
		end
		guard(m);
		@(posedge clk_i);
	endtask : rd

	task automatic gap;
		for (n = 0; n < 400 && match_pulse !== 1'b1; n++)
			@(posedge clk_i);
		guard(n);
		c = 0;
		do
		begin
			@(posedge clk_i);
			c++;
		end
		while (c < 400 && match_pulse !== 1'b1);
		guard(c);
	endtask : gap

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		for (i = 0; i < 5; i++)
		begin
			wr(rows[i].a, rows[i].d);
			chk(32'(r), 32'(rows[i].r));
			rd(rows[i].a);
			chk(d, rows[i].q);
			chk(32'(r), 32'(rows[i].r));
		end
		wstrb <= 4'hE;
		wr(OFS_PERIOD, 32'h12);
		chk(32'(r), 32'(RESP_OKAY));
		wstrb <= 4'hF;
		rd(OFS_PERIOD);
		chk(d, 32'h5A);
		wr(OFS_PERIOD, 32'h3);
		wr(OFS_COUNT, 32'h0);
		for (i = 0; i < 4; i++)
		begin
			wr(OFS_CONTROL, 32'(4 + i));
			gap();
			chk(32'(c), 32'(4 * divs[i]));
		end
		for (i = 0; i < 3; i++)
		begin
			wr(OFS_CONTROL, 32'h0);
			wr(OFS_FLAGS, 32'h0);
			wr(OFS_ENABLES, 32'h2);
			wr(OFS_PERIOD, 32'h7);
			wr(OFS_COUNT, 32'h0);
			wr(OFS_CONTROL, 32'(posts[i] * 8 + 4));
			k = 0;
			for (n = 0; n < 400 && irq !== 1'b1; n++)
			begin
				@(posedge clk_i);
				if (irq !== 1'b1 && match_pulse === 1'b1)
					k++;
			end
			guard(n);
			chk(32'(k), 32'(posts[i] + 1));
		end
		wr(OFS_CONTROL, 32'h0);
		wr(OFS_ENABLES, 32'h0);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq}, 32'h0);
		rd(OFS_FLAGS);
		chk(d, 32'h2);
		wr(OFS_ENABLES, 32'h2);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_FLAGS, 32'h0);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_COUNT, 32'h20);
		wr(OFS_CONTROL, 32'h7B);
		rd(OFS_COUNT);
		chk(d, 32'h20);
		repeat (20) @(posedge clk_i);
		rd(OFS_COUNT);
		chk(d, 32'h20);
		wr(OFS_PERIOD, 32'h11);
		wr(OFS_CONTROL, 32'h7F);
		reset_n_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		rd(OFS_PERIOD);
		chk(d, 32'hFF);
		rd(OFS_COUNT);
		chk(d, 32'h0);
		rd(OFS_CONTROL);
		chk(d, 32'h0);
		summarize();
	end
endmodule : period_match_timer_tb
